// ### logic/umsc_defs.vh
`ifndef UMSC_DEFS_VH
`define UMSC_DEFS_VH

// Register byte offsets on the AXI4-Lite slave
`define UMSC_OFF_MODE 8'h00
`define UMSC_OFF_STATUS 8'h04
`define UMSC_OFF_COMMAND 8'h08
`define UMSC_OFF_RXDATA 8'h0c
`define UMSC_OFF_TXDATA 8'h10

// Mode register pointer codes
`define UMSC_PTR_EXT 2'h0
`define UMSC_PTR_FMT 2'h1
`define UMSC_PTR_LINE 2'h2

// Miscellaneous commands, upper nibble of the command port; enable and disable are 2-bit codes for bits 1-0 and 3-2
`define UMSC_CMD_PTR_FMT 4'h1
`define UMSC_CMD_RESET_RX 4'h2
`define UMSC_CMD_RESET_TX 4'h3
`define UMSC_CMD_RESET_ERR 4'h4
`define UMSC_CMD_RTS_ON 4'h8
`define UMSC_CMD_RTS_OFF 4'h9
`define UMSC_CMD_PTR_EXT 4'hb
`define UMSC_CMD_ENABLE 2'b01
`define UMSC_CMD_DISABLE 2'b10

// Writable bits of the extended mode register per channel
`define UMSC_EXT_MASK_A 8'hf7
`define UMSC_EXT_MASK_B 8'hf0

// Field positions
`define UMSC_EXT_BAUD1 0
`define UMSC_EXT_TEST 1
`define UMSC_EXT_BAUD2 2
`define UMSC_EXT_TXTRIG 4
`define UMSC_EXT_RXTRIG 6
`define UMSC_EXT_WDOG 7
`define UMSC_FMT_LEN 0
`define UMSC_FMT_PTYPE 2
`define UMSC_FMT_PMODE 3
`define UMSC_FMT_ERRMODE 5
`define UMSC_FMT_RXTRIG 6
`define UMSC_FMT_RXRTS 7
`define UMSC_LINE_STOP 0
`define UMSC_LINE_CTS 4
`define UMSC_LINE_TXRTS 5
`define UMSC_LINE_LOOP 6

// Parity and loopback modes
`define UMSC_PAR_WITH 2'h0
`define UMSC_PAR_FORCE 2'h1
`define UMSC_PAR_NONE 2'h2
`define UMSC_PAR_MULTI 2'h3
`define UMSC_LOOP_ECHO 2'h1
`define UMSC_LOOP_LOCAL 2'h2
`define UMSC_LOOP_REMOTE 2'h3

// Reset values
`define UMSC_MODE_RST 8'h00

// Timing in 16x ticks
`define UMSC_HALF_LAST 4'd7
`define UMSC_BIT_LAST 4'd15
`define UMSC_STOP_LO_EXTRA 5'd8
`define UMSC_STOP_HI_EXTRA 5'd16

// AXI responses
`define UMSC_RESP_OKAY 2'b00
`define UMSC_RESP_SLVERR 2'b10

`endif

// ### logic/umsc_channel.v
// Function
// - Extended mode reached after pointer command 0xB; format after reset or 0x1; access advances
// - Line control accesses keep the pointer; only pointer commands and reset move it back
// - Channel A extended bits 0 and 2 pick baud tables, bit 1 test mode
// - Unused extended mode bits ignore writes
// - Transmit trigger field gives empty-location threshold per FIFO depth
// - Receive trigger from extended bit 6 and format bit 6
// - Extended bit 7 enables receive timeout, default off
// - Format bits 1-0 give 5 to 8 data bits
// - Format bit 2 is parity sense, or address flag in multidrop
// - Format bits 4-3 choose with, forced, no parity or multidrop
// - Format bit 5 picks per-character or accumulated error reporting
// - Automatic receive or transmit RTS drive the active-low multipurpose output
// - Line control bits 3-0 set stop length in sixteenth-bit steps
// - Line control bit 4 enables CTS gating of the transmitter
// - Line control bits 7-6 select loopback mode
// - Receive ready while the receive FIFO holds a character
// - FIFO full flag stays while a waiting character refills the FIFO
// - Transmit ready while the transmit FIFO has a free location
// - Transmit empty after last stop bit; cleared by load or disable
// - Overrun on start bit with FIFO full and a waiting character
// - Parity error flag, or received address tag in multidrop
// - Framing error on low stop; line still low half bit later starts anew
// - Break flag; one FIFO entry, then inhibit until line is high
`timescale 1ns/1ps
`include "umsc_defs.vh"

module umsc_channel #(
	parameter IS_CHANNEL_A = 1,
	parameter DEEP16 = 0,
	parameter [7:0] TICK_DIV = 8'd13
)(
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire rx_line,
	input wire cts_n,
	output reg tx_line,
	output reg multipurpose_out_n,
	output reg baud_ext1,
	output reg baud_ext2,
	output reg factory_test,
	output reg timeout_enable,
	output reg rx_trigger_hit,
	output reg tx_trigger_hit
);

	localparam AW = (DEEP16 != 0) ? 4 : 3;
	localparam [4:0] DEPTH_C = (DEEP16 != 0) ? 5'd16 : 5'd8;
	localparam [7:0] EXT_MASK = (IS_CHANNEL_A != 0) ? `UMSC_EXT_MASK_A : `UMSC_EXT_MASK_B;
	localparam [6:0] R_IDLE = 7'b0000001, R_START = 7'b0000010, R_DATA = 7'b0000100,
		R_PAR = 7'b0001000, R_STOP = 7'b0010000, R_GAP = 7'b0100000, R_BRK = 7'b1000000;
	localparam [4:0] T_IDLE = 5'b00001, T_START = 5'b00010, T_DATA = 5'b00100,
		T_PAR = 5'b01000, T_STOP = 5'b10000;

	function addr_known;
		input [7:0] a;
		begin
			addr_known = (a == `UMSC_OFF_MODE) || (a == `UMSC_OFF_STATUS) ||
				(a == `UMSC_OFF_COMMAND) || (a == `UMSC_OFF_RXDATA) || (a == `UMSC_OFF_TXDATA);
		end
	endfunction

	// Parity over the active data bits only
	function parity_of;
		input [7:0] d;
		input [1:0] len;
		begin
			parity_of = ^(d & (8'hff >> (2'd3 - len)));
		end
	endfunction

	function [4:0] tx_level;
		input [1:0] code;
		begin
			case (code)
				2'd0: tx_level = DEPTH_C;
				2'd1: tx_level = (DEEP16 != 0) ? 5'd6 : 5'd4;
				2'd2: tx_level = (DEEP16 != 0) ? 5'd12 : 5'd6;
				default: tx_level = 5'd1;
			endcase
		end
	endfunction

	function [4:0] rx_level;
		input [1:0] code;
		begin
			case (code)
				2'd0: rx_level = 5'd1;
				2'd1: rx_level = (DEEP16 != 0) ? 5'd6 : 5'd3;
				2'd2: rx_level = (DEEP16 != 0) ? 5'd12 : 5'd6;
				default: rx_level = DEPTH_C;
			endcase
		end
	endfunction

	reg [7:0] extended_mode, char_format_mode, line_control_mode;
	reg [1:0] mode_ptr;
	reg rx_en, tx_en, rts_req_n;
	reg aw_held, w_held, aw_ok, w_lane;
	reg [7:0] aw_addr, w_data;
	reg [7:0] div_cnt;
	reg tick;
	reg [6:0] rstate;
	reg [3:0] rtick;
	reg [2:0] rbits;
	reg [7:0] rshift;
	reg rpar, rx_push, ovr_pulse;
	reg [10:0] rx_char, hold;
	reg hold_valid, overrun, acc_pe, acc_fe, acc_brk;
	reg [10:0] rx_mem [0:DEPTH_C-1];
	reg [AW-1:0] rx_wp, rx_rp, tx_wp, tx_rp;
	reg [4:0] rx_cnt, tx_cnt;
	reg [7:0] tx_mem [0:DEPTH_C-1];
	reg [4:0] tstate;
	reg [4:0] ttick;
	reg [2:0] tbits;
	reg [7:0] tshift;
	reg tpar, tx_bit, tx_empty;
	reg [7:0] rd_value;

	// Field decode
	wire [1:0] char_len = char_format_mode[`UMSC_FMT_LEN +: 2];
	wire par_sense = char_format_mode[`UMSC_FMT_PTYPE];
	wire [1:0] par_mode = char_format_mode[`UMSC_FMT_PMODE +: 2];
	wire err_block = char_format_mode[`UMSC_FMT_ERRMODE];
	wire auto_rx_rts = char_format_mode[`UMSC_FMT_RXRTS];
	wire [3:0] stop_code = line_control_mode[`UMSC_LINE_STOP +: 4];
	wire auto_cts = line_control_mode[`UMSC_LINE_CTS];
	wire auto_tx_rts = line_control_mode[`UMSC_LINE_TXRTS];
	wire [1:0] loop_mode = line_control_mode[`UMSC_LINE_LOOP +: 2];
	wire [2:0] last_bit = {1'b0, char_len} + 3'd4;
	wire par_used = (par_mode != `UMSC_PAR_NONE);
	wire [4:0] stop_last = stop_code[3] ? {1'b0, stop_code} + `UMSC_STOP_HI_EXTRA
		: {1'b0, stop_code} + `UMSC_STOP_LO_EXTRA;

	// Bus strobes; a read wins a cycle over a write so pointer moves never collide
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire do_write = aw_held & w_held & ~s_axi_bvalid & ~ar_take;
	wire aw_held_nx = aw_take | (aw_held & ~do_write);
	wire w_held_nx = w_take | (w_held & ~do_write);
	wire wr_hit = do_write & w_lane & aw_ok;
	wire wr_mode = wr_hit & (aw_addr == `UMSC_OFF_MODE);
	wire wr_cmd = wr_hit & (aw_addr == `UMSC_OFF_COMMAND);
	wire wr_tx = wr_hit & (aw_addr == `UMSC_OFF_TXDATA);
	wire [3:0] misc = w_data[7:4];
	wire cmd_ptr_ext = wr_cmd & (misc == `UMSC_CMD_PTR_EXT);
	wire cmd_ptr_fmt = wr_cmd & (misc == `UMSC_CMD_PTR_FMT);
	wire cmd_reset_rx = wr_cmd & (misc == `UMSC_CMD_RESET_RX);
	wire cmd_reset_tx = wr_cmd & (misc == `UMSC_CMD_RESET_TX);
	wire cmd_reset_err = wr_cmd & (misc == `UMSC_CMD_RESET_ERR);
	wire cmd_tx_dis = wr_cmd & (w_data[3:2] == `UMSC_CMD_DISABLE);
	wire ra_ok = (s_axi_araddr[31:8] == 24'h0) & addr_known(s_axi_araddr[7:0]);
	wire rd_mode = ar_take & ra_ok & (s_axi_araddr[7:0] == `UMSC_OFF_MODE);
	wire rd_rx = ar_take & ra_ok & (s_axi_araddr[7:0] == `UMSC_OFF_RXDATA);

	// FIFO level terms
	wire rx_full = (rx_cnt == DEPTH_C);
	wire rx_pop = rd_rx & (rx_cnt != 5'd0);
	wire push_hold = rx_pop & hold_valid;
	wire push_new = rx_push & ~hold_valid & (~rx_full | rx_pop);
	wire rx_wr = push_hold | push_new;
	wire [10:0] push_data = push_hold ? hold : rx_char;
	wire to_hold = rx_push & (hold_valid | (rx_full & ~rx_pop));
	wire [10:0] head = rx_mem[rx_rp];
	wire tx_full = (tx_cnt == DEPTH_C);
	wire tx_push = wr_tx & ~tx_full;
	wire tx_pull = tstate[0] & tick & tx_en & (tx_cnt != 5'd0) & (~auto_cts | ~cts_n);
	wire tx_empty_set = tx_en & tstate[0] & (tx_cnt == 5'd0) & ~tx_push & ~cmd_tx_dis;
	wire line_in = (loop_mode == `UMSC_LOOP_LOCAL) ? tx_bit : rx_line;
	wire rx_on = rx_en & (loop_mode != `UMSC_LOOP_REMOTE);
	wire [2:0] flags = err_block ? {acc_brk, acc_fe, acc_pe}
		: ((rx_cnt != 5'd0) ? head[10:8] : 3'b000);
	wire [7:0] status = {flags, overrun, tx_empty, ~tx_full, rx_full, rx_cnt != 5'd0};

	// Mode registers, pointer and command effects
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			extended_mode <= `UMSC_MODE_RST;
			char_format_mode <= `UMSC_MODE_RST;
			line_control_mode <= `UMSC_MODE_RST;
			mode_ptr <= `UMSC_PTR_FMT;
			rx_en <= 1'b0;
			tx_en <= 1'b0;
			rts_req_n <= 1'b1;
		end
		else
		begin
			if (wr_mode)
			begin
				if (mode_ptr == `UMSC_PTR_EXT)
					extended_mode <= w_data & EXT_MASK;
				else if (mode_ptr == `UMSC_PTR_FMT)
					char_format_mode <= w_data;
				else
					line_control_mode <= w_data;
			end
			if (cmd_ptr_ext)
				mode_ptr <= `UMSC_PTR_EXT;
			else if (cmd_ptr_fmt)
				mode_ptr <= `UMSC_PTR_FMT;
			else if ((wr_mode | rd_mode) && mode_ptr != `UMSC_PTR_LINE)
				mode_ptr <= mode_ptr + 2'd1;
			if (cmd_reset_rx || (wr_cmd && w_data[1:0] == `UMSC_CMD_DISABLE))
				rx_en <= 1'b0;
			else if (wr_cmd && w_data[1:0] == `UMSC_CMD_ENABLE)
				rx_en <= 1'b1;
			if (cmd_reset_tx || cmd_tx_dis)
				tx_en <= 1'b0;
			else if (wr_cmd && w_data[3:2] == `UMSC_CMD_ENABLE)
				tx_en <= 1'b1;
			// Transmit RTS drops once the line has gone idle
			if (wr_cmd && misc == `UMSC_CMD_RTS_ON)
				rts_req_n <= 1'b0;
			else if (wr_cmd && misc == `UMSC_CMD_RTS_OFF)
				rts_req_n <= 1'b1;
			else if (auto_tx_rts && tx_empty_set && !tx_empty)
				rts_req_n <= 1'b1;
		end
	end

	// Read data select
	always @*
	begin
		rd_value = 8'h00;
		if (s_axi_araddr[7:0] == `UMSC_OFF_MODE)
			rd_value = (mode_ptr == `UMSC_PTR_EXT) ? extended_mode
				: (mode_ptr == `UMSC_PTR_FMT) ? char_format_mode : line_control_mode;
		else if (s_axi_araddr[7:0] == `UMSC_OFF_STATUS)
			rd_value = status;
		else if (s_axi_araddr[7:0] == `UMSC_OFF_RXDATA)
			rd_value = head[7:0];
	end

	// AXI4-Lite handshakes
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `UMSC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `UMSC_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_ok <= 1'b0;
			w_lane <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 8'h00;
		end
		else
		begin
			s_axi_awready <= ~aw_held_nx;
			s_axi_wready <= ~w_held_nx;
			aw_held <= aw_held_nx;
			w_held <= w_held_nx;
			if (aw_take)
			begin
				aw_addr <= s_axi_awaddr[7:0];
				aw_ok <= (s_axi_awaddr[31:8] == 24'h0) & addr_known(s_axi_awaddr[7:0]);
			end
			if (w_take)
			begin
				w_data <= s_axi_wdata[7:0];
				w_lane <= s_axi_wstrb[0];
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= aw_ok ? `UMSC_RESP_OKAY : `UMSC_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (ar_take)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= ra_ok ? {24'h000000, rd_value} : 32'h00000000;
				s_axi_rresp <= ra_ok ? `UMSC_RESP_OKAY : `UMSC_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			else if (!s_axi_rvalid)
				s_axi_arready <= 1'b1;
		end
	end

	// 16x bit-rate enable; the baud table lives outside this block
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_cnt <= 8'h00;
			tick <= 1'b0;
		end
		else if (div_cnt >= TICK_DIV - 8'd1)
		begin
			div_cnt <= 8'h00;
			tick <= 1'b1;
		end
		else
		begin
			div_cnt <= div_cnt + 8'd1;
			tick <= 1'b0;
		end
	end

	// Receive shifter; rx_char holds {break, framing, parity-or-tag, data}
	always @(posedge aclk)
	begin
		if (!aresetn || cmd_reset_rx)
		begin
			rstate <= R_IDLE;
			rtick <= 4'd0;
			rbits <= 3'd0;
			rshift <= 8'h00;
			rpar <= 1'b0;
			rx_push <= 1'b0;
			ovr_pulse <= 1'b0;
			rx_char <= 11'h000;
		end
		else
		begin
			rx_push <= 1'b0;
			ovr_pulse <= 1'b0;
			if (tick)
			begin
				rtick <= rtick + 4'd1;
				case (rstate)
					R_IDLE:
					begin
						rtick <= 4'd0;
						if (rx_on && !line_in)
							rstate <= R_START;
					end
					R_START:
						if (rtick == `UMSC_HALF_LAST)
						begin
							rtick <= 4'd0;
							rbits <= 3'd0;
							rshift <= 8'h00;
							rstate <= line_in ? R_IDLE : R_DATA;
							ovr_pulse <= ~line_in & rx_full & hold_valid;
						end
					R_DATA:
						if (rtick == `UMSC_BIT_LAST)
						begin
							rshift[rbits] <= line_in;
							rbits <= rbits + 3'd1;
							if (rbits == last_bit)
								rstate <= par_used ? R_PAR : R_STOP;
						end
					R_PAR:
						if (rtick == `UMSC_BIT_LAST)
						begin
							rpar <= line_in;
							rstate <= R_STOP;
						end
					R_STOP:
						if (rtick == `UMSC_BIT_LAST)
						begin
							rx_push <= 1'b1;
							rx_char[7:0] <= rshift;
							rx_char[8] <= (par_mode == `UMSC_PAR_MULTI) ? rpar
								: (par_mode == `UMSC_PAR_FORCE) ? (rpar != par_sense)
								: (par_mode == `UMSC_PAR_WITH) ?
								(rpar != (parity_of(rshift, char_len) ^ par_sense)) : 1'b0;
							rx_char[9] <= ~line_in & ((rshift != 8'h00) | (par_used & rpar));
							rx_char[10] <= ~line_in & (rshift == 8'h00) & ~(par_used & rpar);
							rtick <= 4'd0;
							rpar <= 1'b0;
							if (line_in)
								rstate <= R_IDLE;
							else if (rshift == 8'h00 && !(par_used && rpar))
								rstate <= R_BRK;
							else
								rstate <= R_GAP;
						end
					R_GAP:
						if (rtick == `UMSC_HALF_LAST)
						begin
							rtick <= 4'd0;
							rstate <= line_in ? R_IDLE : R_START;
						end
					R_BRK:
						if (line_in)
							rstate <= R_IDLE;
					default:
						rstate <= R_IDLE;
				endcase
			end
		end
	end

	// Receive FIFO with one waiting slot behind it
	always @(posedge aclk)
	begin
		if (rx_wr)
			rx_mem[rx_wp] <= push_data;
	end

	always @(posedge aclk)
	begin
		if (!aresetn || cmd_reset_rx)
		begin
			rx_wp <= {AW{1'b0}};
			rx_rp <= {AW{1'b0}};
			rx_cnt <= 5'd0;
			hold <= 11'h000;
			hold_valid <= 1'b0;
		end
		else
		begin
			if (rx_wr)
				rx_wp <= rx_wp + 1'b1;
			if (rx_pop)
				rx_rp <= rx_rp + 1'b1;
			if (rx_wr && !rx_pop)
				rx_cnt <= rx_cnt + 5'd1;
			else if (rx_pop && !rx_wr)
				rx_cnt <= rx_cnt - 5'd1;
			// A late character overwrites the waiting one with its flags
			if (to_hold)
			begin
				hold <= rx_char;
				hold_valid <= 1'b1;
			end
			else if (push_hold)
				hold_valid <= 1'b0;
		end
	end

	// Error flags; a new event beats a clear in the same cycle
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			overrun <= 1'b0;
			acc_pe <= 1'b0;
			acc_fe <= 1'b0;
			acc_brk <= 1'b0;
		end
		else
		begin
			overrun <= ovr_pulse | (overrun & ~cmd_reset_err);
			acc_pe <= (rx_wr & push_data[8]) | (acc_pe & ~cmd_reset_err);
			acc_fe <= (rx_wr & push_data[9]) | (acc_fe & ~cmd_reset_err);
			acc_brk <= (rx_wr & push_data[10]) | (acc_brk & ~cmd_reset_err);
		end
	end

	// Transmit FIFO
	always @(posedge aclk)
	begin
		if (tx_push)
			tx_mem[tx_wp] <= w_data;
	end

	always @(posedge aclk)
	begin
		if (!aresetn || cmd_reset_tx)
		begin
			tx_wp <= {AW{1'b0}};
			tx_rp <= {AW{1'b0}};
			tx_cnt <= 5'd0;
		end
		else
		begin
			if (tx_push)
				tx_wp <= tx_wp + 1'b1;
			if (tx_pull)
				tx_rp <= tx_rp + 1'b1;
			if (tx_push && !tx_pull)
				tx_cnt <= tx_cnt + 5'd1;
			else if (tx_pull && !tx_push)
				tx_cnt <= tx_cnt - 5'd1;
		end
	end

	// Transmit shifter; idle line is mark
	always @(posedge aclk)
	begin
		if (!aresetn || cmd_reset_tx)
		begin
			tstate <= T_IDLE;
			ttick <= 5'd0;
			tbits <= 3'd0;
			tshift <= 8'h00;
			tpar <= 1'b0;
			tx_bit <= 1'b1;
		end
		else if (tick)
		begin
			ttick <= ttick + 5'd1;
			case (tstate)
				T_IDLE:
				begin
					ttick <= 5'd0;
					tx_bit <= 1'b1;
					if (tx_pull)
					begin
						tshift <= tx_mem[tx_rp];
						tpar <= (par_mode == `UMSC_PAR_WITH) ?
							(parity_of(tx_mem[tx_rp], char_len) ^ par_sense) : par_sense;
						tbits <= 3'd0;
						tx_bit <= 1'b0;
						tstate <= T_START;
					end
				end
				T_START, T_DATA:
					if (ttick[3:0] == `UMSC_BIT_LAST)
					begin
						ttick <= 5'd0;
						if (tstate == T_START)
						begin
							tx_bit <= tshift[0];
							tstate <= T_DATA;
						end
						else if (tbits == last_bit)
						begin
							tx_bit <= par_used ? tpar : 1'b1;
							tstate <= par_used ? T_PAR : T_STOP;
						end
						else
						begin
							tx_bit <= tshift[1];
							tshift <= {1'b0, tshift[7:1]};
							tbits <= tbits + 3'd1;
						end
					end
				T_PAR:
					if (ttick[3:0] == `UMSC_BIT_LAST)
					begin
						ttick <= 5'd0;
						tx_bit <= 1'b1;
						tstate <= T_STOP;
					end
				T_STOP:
					if (ttick == stop_last)
						tstate <= T_IDLE;
				default:
					tstate <= T_IDLE;
			endcase
		end
	end

	// Status and pin outputs
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_empty <= 1'b0;
			tx_line <= 1'b1;
			multipurpose_out_n <= 1'b1;
			baud_ext1 <= 1'b0;
			baud_ext2 <= 1'b0;
			factory_test <= 1'b0;
			timeout_enable <= 1'b0;
			rx_trigger_hit <= 1'b0;
			tx_trigger_hit <= 1'b0;
		end
		else
		begin
			if (tx_push || cmd_tx_dis || cmd_reset_tx)
				tx_empty <= 1'b0;
			else if (tx_empty_set)
				tx_empty <= 1'b1;
			if (loop_mode == `UMSC_LOOP_LOCAL)
				tx_line <= 1'b1;
			else if (loop_mode == `UMSC_LOOP_ECHO || loop_mode == `UMSC_LOOP_REMOTE)
				tx_line <= rx_line;
			else
				tx_line <= tx_bit;
			multipurpose_out_n <= rts_req_n | (auto_rx_rts & rx_full);
			baud_ext1 <= extended_mode[`UMSC_EXT_BAUD1];
			baud_ext2 <= extended_mode[`UMSC_EXT_BAUD2];
			factory_test <= extended_mode[`UMSC_EXT_TEST];
			timeout_enable <= extended_mode[`UMSC_EXT_WDOG];
			rx_trigger_hit <= rx_cnt >= rx_level({extended_mode[`UMSC_EXT_RXTRIG],
				char_format_mode[`UMSC_FMT_RXTRIG]});
			tx_trigger_hit <= (DEPTH_C - tx_cnt) >= tx_level(extended_mode[`UMSC_EXT_TXTRIG +: 2]);
		end
	end

endmodule

// ### test/umsc_channel_checker.sv
`timescale 1ns/1ps
`include "umsc_defs.vh"

module umsc_channel_checker (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire baud_ext1,
	input wire baud_ext2,
	input wire factory_test,
	input wire timeout_enable
);
	reg [31:0] rd_addr;
	reg ovr_seen;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire st_rd = s_axi_rvalid && rd_addr == `UMSC_OFF_STATUS;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Any reset-error write forgets the overrun, so the check errs on the lenient side
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_addr <= 32'h0;
			ovr_seen <= 1'b0;
		end
		else
		begin
			if (ar_take)
				rd_addr <= s_axi_araddr;
			if (s_axi_wvalid && s_axi_wready && s_axi_wdata[7:4] == `UMSC_CMD_RESET_ERR)
				ovr_seen <= 1'b0;
			else if (st_rd && s_axi_rready && s_axi_rdata[4])
				ovr_seen <= 1'b1;
		end
	end

	mode_out_a:
	assert property ($changed({baud_ext1, baud_ext2, factory_test, timeout_enable})
		|-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
		else $error("mode outputs moved without a write");
	full_ready_a:
	assert property (st_rd && s_axi_rdata[1] |-> s_axi_rdata[0]) else $error("full without ready");
	tx_empty_a:
	assert property (st_rd && s_axi_rdata[3] |-> s_axi_rdata[2]) else $error("empty but not ready");
	ovr_hold_a:
	assert property (st_rd && ovr_seen |-> s_axi_rdata[4]) else $error("overrun lost");
	bad_addr_a:
	assert property (ar_take && s_axi_araddr[31:8] != 24'h0 |=> s_axi_rvalid
		&& s_axi_rresp == `UMSC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read");
	read_ans_a:
	assert property (ar_take |=> s_axi_rvalid && !s_axi_arready) else $error("late read");
	rd_hold_a:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	wr_ans_a:
	assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[2:3] s_axi_bvalid) else $error("late write response");

	cover property (st_rd && s_axi_rdata[4]);
	cover property (st_rd && s_axi_rdata[1]);
	cover property (ar_take && s_axi_araddr[31:8] != 24'h0);
endmodule

bind umsc_channel umsc_channel_checker i_umsc_channel_checker (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .baud_ext1(baud_ext1), .baud_ext2(baud_ext2),
	.factory_test(factory_test), .timeout_enable(timeout_enable));

// ### test/umsc_remote_station.sv
`timescale 1ns/1ps

module umsc_remote_station #(
	parameter BIT = 16
)(
	input wire aclk,
	input wire tx_line,
	output reg rx_line
);
	reg [7:0] got = 8'h00;
	integer got_count = 0;
	integer i;

	initial
		rx_line = 1'b1;

	// Eight data bits, no parity; a bad stop is cut short so no new start follows
	task send(input [7:0] d, input stop_ok);
		reg [9:0] frame;
		integer k;
		begin
			frame = {stop_ok, d, 1'b0};
			for (k = 0; k < 10; k = k + 1)
			begin
				rx_line <= frame[k];
				repeat ((k == 9 && !stop_ok) ? BIT / 2 + 3 : BIT) @(posedge aclk);
			end
			rx_line <= 1'b1;
			repeat (BIT) @(posedge aclk);
		end
	endtask

	// Mid-bit sampling, LSB first
	always
	begin
		@(negedge tx_line);
		repeat (BIT / 2) @(posedge aclk);
		for (i = 0; i < 8; i = i + 1)
		begin
			repeat (BIT) @(posedge aclk);
			got[i] = tx_line;
		end
		repeat (BIT) @(posedge aclk);
		got_count = got_count + 1;
	end
endmodule

// ### test/test_uart_mode_status_channel.sv
`timescale 1ns/1ps
`include "umsc_defs.vh"

module test_uart_mode_status_channel;
	localparam [31:0] M = `UMSC_OFF_MODE;
	localparam [31:0] S = `UMSC_OFF_STATUS;
	localparam [31:0] C = `UMSC_OFF_COMMAND;
	localparam [31:0] R = `UMSC_OFF_RXDATA;
	localparam [31:0] T = `UMSC_OFF_TXDATA;
	localparam [1:0] OK = `UMSC_RESP_OKAY;
	localparam [1:0] ER = `UMSC_RESP_SLVERR;
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg [31:0] awaddr = 32'h0;
	reg [31:0] wdata = 32'h0;
	reg [31:0] araddr = 32'h0;
	reg awvalid = 1'b0;
	reg wvalid = 1'b0;
	reg arvalid = 1'b0;
	reg bready = 1'b0;
	reg rready = 1'b0;
	reg [3:0] wstrb = 4'h1;
	reg [31:0] rbyte;
	wire awready, wready, bvalid, arready, rvalid, tx_line, rx_line, rts_n;
	wire ext1, ext2, ftest, wdog, rx_hit, tx_hit;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer failures = 0;
	integer cmp_count = 0;
	integer n;
	integer k;

	always #20 aclk = ~aclk;

	umsc_channel #(.IS_CHANNEL_A(1), .DEEP16(0), .TICK_DIV(8'd1)) i_umsc_channel (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_line(rx_line),
		.cts_n(1'b0), .tx_line(tx_line), .multipurpose_out_n(rts_n), .baud_ext1(ext1),
		.baud_ext2(ext2), .factory_test(ftest), .timeout_enable(wdog),
		.rx_trigger_hit(rx_hit), .tx_trigger_hit(tx_hit));

	umsc_remote_station #(.BIT(16)) i_umsc_remote_station (.aclk(aclk), .tx_line(tx_line),
		.rx_line(rx_line));

	task print_verdict;
		begin
			$display("compares %0d mismatches %0d", cmp_count, failures);
			if (failures == 0 && cmp_count > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	task chk(input [31:0] got, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp)
			begin
				failures = failures + 1;
				$display("ERROR %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// Every open-ended wait passes through here, so a hang ends in the report
	task tick;
		begin
			@(posedge aclk);
			n = n + 1;
			if (n > 2000)
			begin
				failures = failures + 1;
				$display("ERROR %0t wait timed out", $time);
				print_verdict;
			end
		end
	endtask

	// Response ready stands until the answer; an edge passes before the next call
	task wr(input [31:0] a, input [7:0] d, input [1:0] er);
		begin
			awaddr <= a;
			wdata <= {24'h0, d};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			n = 0;
			do
			begin
				tick;
				if (awready)
					awvalid <= 1'b0;
				if (wready)
					wvalid <= 1'b0;
			end
			while (!bvalid);
			bready <= 1'b0;
			chk(bresp, er);
			tick;
		end
	endtask

	task rd_raw(input [31:0] a);
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			n = 0;
			do
			begin
				tick;
				if (arready)
					arvalid <= 1'b0;
			end
			while (!rvalid);
			rready <= 1'b0;
			rbyte = rdata;
			tick;
		end
	endtask

	task rd(input [31:0] a, input [7:0] exp, input [1:0] er);
		begin
			rd_raw(a);
			chk(rbyte, {24'h0, exp});
			chk(rresp, er);
		end
	endtask

	// Bounded status polling for a bit to come up
	task poll(input [7:0] m);
		begin
			k = 0;
			rd_raw(S);
			while ((rbyte[7:0] & m) == 8'h0 && k < 300)
			begin
				rd_raw(S);
				k = k + 1;
			end
			chk(rbyte[7:0] & m, m);
		end
	endtask

	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(M, 8'h00, OK);
		rd(M, 8'h00, OK);
		wr(C, 8'hb0, OK);
		wr(M, 8'h8d, OK);
		wr(M, 8'h13, OK);
		wr(M, 8'h07, OK);
		rd(M, 8'h07, OK);
		wr(C, 8'hb0, OK);
		rd(M, 8'h85, OK);
		rd(M, 8'h13, OK);
		chk({wdog, ftest, ext2, ext1}, 4'b1011);
		wr(C, 8'h10, OK);
		rd(M, 8'h13, OK);
		wr(32'h100, 8'h00, ER);
		rd(32'h100, 8'h00, ER);
		wr(C, 8'h05, OK);
		wr(C, 8'h80, OK);
		chk(rts_n, 1'b0);
		wr(C, 8'h90, OK);
		chk(rts_n, 1'b1);
		chk(tx_hit, 1'b1);
		rd(S, 8'h0c, OK);
		wr(T, 8'ha5, OK);
		rd(S, 8'h04, OK);
		n = 0;
		while (i_umsc_remote_station.got_count == 0)
			tick;
		chk(i_umsc_remote_station.got, 8'ha5);
		poll(8'h08);
		wstrb <= 4'h0;
		wr(T, 8'h55, OK);
		wstrb <= 4'h1;
		rd(S, 8'h0c, OK);
		i_umsc_remote_station.send(8'h3c, 1'b1);
		rd(S, 8'h0d, OK);
		chk(rx_hit, 1'b1);
		rd(R, 8'h3c, OK);
		rd(S, 8'h0c, OK);
		i_umsc_remote_station.send(8'h01, 1'b0);
		poll(8'h01);
		rd(S, 8'h4d, OK);
		rd(R, 8'h01, OK);
		rd(S, 8'h0c, OK);
		for (k = 0; k < 10; k = k + 1)
			i_umsc_remote_station.send(8'h10 + k[7:0], 1'b1);
		rd(S, 8'h1f, OK);
		rd(R, 8'h10, OK);
		rd(S, 8'h1f, OK);
		for (k = 1; k < 8; k = k + 1)
			rd(R, 8'h10 + k[7:0], OK);
		rd(R, 8'h19, OK);
		rd(S, 8'h1c, OK);
		wr(C, 8'h40, OK);
		rd(S, 8'h0c, OK);
		print_verdict;
	end
endmodule
